// *** design/pwd_top.v ***
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "pwd_defs.vh"

module pwd_top #(
   parameter COUNT_W = 30,
   parameter LIMIT_0 = `PWD_LIMIT_0,
   parameter LIMIT_1 = `PWD_LIMIT_1,
   parameter LIMIT_2 = `PWD_LIMIT_2,
   parameter LIMIT_3 = `PWD_LIMIT_3,
   parameter LIMIT_4 = `PWD_LIMIT_4,
   parameter LIMIT_5 = `PWD_LIMIT_5,
   parameter LIMIT_6 = `PWD_LIMIT_6,
   parameter LIMIT_7 = `PWD_LIMIT_7
) (
   input wire clk,
   input wire rst_n,
   input wire ce,
   // Register port
   input wire [7:0] addr,
   input wire [7:0] wdata,
   input wire wr,
   input wire rd,
   output reg [7:0] rdata,
   // Shared protection and interrupt controller inputs
   input wire timed_access_guard,
   input wire watchdog_interrupt_enable,
   // CPU power state, high while idle or stopped
   input wire cpu_halted,
   // Reset controller level, high when last reset was the watchdog
   input wire wdt_reset_cause,
   // Requests toward the system
   output reg wdt_irq_req,
   output reg sys_reset_req,
   output reg irq,
   // Timer divisor bits kept here for the timer blocks
   output reg [2:0] timer_divisor_select
);

   // Watchdog control and status storage
   // Set by every expiry, cleared only by software
   reg expiry_flag;
   // Remembers that the last reset came from this watchdog
   reg watchdog_reset_flag;
   // High lets an expiry request a system reset
   reg reset_enable;

   // Timeout select code, bit 2 down to bit 0
   reg [2:0] timeout_select;

   // Interrupt status, sticky, write one to clear
   reg [1:0] int_status;
   // Interrupt mask, same layout as the status
   reg [1:0] int_mask;

   // Reset cause synchroniser, first stage
   reg cause_meta;
   // Reset cause synchroniser, second stage
   reg cause_sync;
   // Edges since reset release
   reg [1:0] settle_count;
   // High once the cause has been looked at
   reg cause_taken;

   // One cycle pulse from the counter at the terminal value
   wire expire;
   // Terminal count for the selected code
   wire [COUNT_W-1:0] terminal;

   // Decoded write strobes, one per register
   wire wr_ctl;
   wire wr_ck;
   wire wr_stat;
   wire wr_mask;

   // Restart write seen on the port
   wire restart_hit;
   // Restart write with the guard open
   wire restart_ok;
   // Restart write with the guard shut
   wire restart_refused;

   // Next read data, registered on a read strobe
   reg [7:0] next_rdata;

   // Terminal count for a select code, one below the expiry count
   function [COUNT_W-1:0] limit_of;
      input [2:0] sel;
      reg [31:0] lim;
      begin
         lim = 32'h0000_0000;
         // Codes 0 to 7, longer periods as the code rises
         case (sel)
            3'h0: lim = LIMIT_0;
            3'h1: lim = LIMIT_1;
            3'h2: lim = LIMIT_2;
            3'h3: lim = LIMIT_3;
            3'h4: lim = LIMIT_4;
            3'h5: lim = LIMIT_5;
            3'h6: lim = LIMIT_6;
            default: lim = LIMIT_7;
         endcase
         // Counter runs from zero, so the terminal is one below the count
         // A full 2^30 count truncates to zero and wraps to all ones here,
         // which still gives the right period without a wider counter
         limit_of = lim[COUNT_W-1:0] - {{(COUNT_W-1){1'b0}}, 1'b1};
      end
   endfunction

   // Address compare, used for every write decode
   // The strobe is an argument so the decode follows it as well as the address
   function is_write;
      input w;
      input [7:0] a;
      input [7:0] target;
      begin
         is_write = w && (a == target);
      end
   endfunction

   // One strobe per register, unmapped writes fall through
   assign wr_ctl = is_write(wr, addr, `PWD_ADDR_CONTROL);
   assign wr_ck = is_write(wr, addr, `PWD_ADDR_CLOCK_TIMEOUT);
   assign wr_stat = is_write(wr, addr, `PWD_ADDR_INT_STATUS);
   assign wr_mask = is_write(wr, addr, `PWD_ADDR_INT_MASK);

   // Restart decode, only bit 0 is guarded
   // restart on a written one
   assign restart_hit = wr_ctl && wdata[`PWD_CTL_RESTART];
   assign restart_ok = restart_hit && timed_access_guard;
   assign restart_refused = restart_hit && !timed_access_guard;

   // select to count mapping
   // Terminal follows the select at once, the counter compares with >=
   assign terminal = limit_of(timeout_select);

   // halted CPU stops the count
   // Restart clears even while halted, so a restart is never lost
   pwd_counter #(
      .COUNT_W(COUNT_W)
   ) u_counter (
      .clk(clk),
      .rst_n(rst_n),
      .ce(ce),
      .run(!cpu_halted),
      .clear(restart_ok),
      .terminal(terminal),
      .expire(expire)
   );

   // Reset cause crosses in from the reset controller
   // Only the second stage feeds the catch logic
   // Reset clears both stages, so a stale cause cannot leak through
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cause_meta <= 1'b0;
         cause_sync <= 1'b0;
      end else if (ce) begin
         cause_meta <= wdt_reset_cause;
         cause_sync <= cause_meta;
      end
   end

   // Wait for the synchroniser to fill before catching the cause
   // Counts 0 to 3 once after each release, then parks
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         settle_count <= 2'h0;
         cause_taken <= 1'b0;
      end else if (ce) begin
         if (settle_count != `PWD_CAUSE_SETTLE) begin
            settle_count <= settle_count + 2'h1;
         end else begin
            // Cause looked at once, later changes are ignored
            cause_taken <= 1'b1;
         end
      end
   end

   // Watchdog control and status register
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         // reads 0x02 after reset
         // Expiry flag starts clear
         expiry_flag <= 1'b0;
         watchdog_reset_flag <= 1'b0;
         // Reset function on by default
         reset_enable <= 1'b1;
      end else if (ce) begin
         if (expire) begin
            expiry_flag <= 1'b1;
         end else if (wr_ctl) begin
            // only a software write clears it
            expiry_flag <= wdata[`PWD_CTL_EXPIRY_FLAG];
         end
         // caught once after a watchdog reset
         if (settle_count == `PWD_CAUSE_SETTLE && !cause_taken && cause_sync) begin
            watchdog_reset_flag <= 1'b1;
         end else if (wr_ctl) begin
            watchdog_reset_flag <= wdata[`PWD_CTL_RESET_FLAG];
         end
         // written with no unlock
         // Flag bits above are plain writes as well
         if (wr_ctl) begin
            reset_enable <= wdata[`PWD_CTL_RESET_ENABLE];
         end
      end
   end

   // Clock and timeout control register
   // Divisor bits are only stored here for the timer blocks
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         // Longest timeout, divisors off
         timeout_select <= `PWD_RST_TIMEOUT_SEL;
         timer_divisor_select <= `PWD_RST_DIVISORS;
      end else if (ce) begin
         if (wr_ck) begin
            timeout_select <= {wdata[`PWD_CK_SEL_BIT2], wdata[`PWD_CK_SEL_BIT1], wdata[`PWD_CK_SEL_BIT0]};
            timer_divisor_select <= wdata[`PWD_CK_DIV_HI:`PWD_CK_DIV_LO];
         end
      end
   end

   // Sticky interrupt status, write one to clear, set beats clear
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         int_status <= `PWD_RST_INT_STATUS;
         int_mask <= `PWD_RST_INT_MASK;
      end else if (ce) begin
         // Expiry event, a clear in the same cycle loses
         if (expire) begin
            int_status[`PWD_INT_EXPIRY] <= 1'b1;
         end else if (wr_stat && wdata[`PWD_INT_EXPIRY]) begin
            int_status[`PWD_INT_EXPIRY] <= 1'b0;
         end
         // refused restart is logged, a clear in the same cycle loses
         if (restart_refused) begin
            int_status[`PWD_INT_REFUSED] <= 1'b1;
         end else if (wr_stat && wdata[`PWD_INT_REFUSED]) begin
            int_status[`PWD_INT_REFUSED] <= 1'b0;
         end
         // Mask is plain read and write
         if (wr_mask) begin
            int_mask <= wdata[1:0];
         end
      end
   end

   // Requests toward the system, all registered
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wdt_irq_req <= 1'b0;
         sys_reset_req <= 1'b0;
         irq <= 1'b0;
      end else if (ce) begin
         // gated by the interrupt enable
         // The pulse term saves a cycle of lag behind the flag
         wdt_irq_req <= (expiry_flag || expire) && watchdog_interrupt_enable;
         // reset only when enabled; held until reset arrives
         // Sticky: only rst_n takes the request back down
         if (expire && reset_enable) begin
            sys_reset_req <= 1'b1;
         end
         // Interrupt line, one cycle behind the status
         irq <= |(int_status & int_mask);
      end
   end

   // Read data mux, unmapped addresses read zero
   always @* begin
      next_rdata = 8'h00;
      case (addr)
         `PWD_ADDR_CONTROL: begin
            next_rdata[`PWD_CTL_EXPIRY_FLAG] = expiry_flag;
            next_rdata[`PWD_CTL_RESET_FLAG] = watchdog_reset_flag;
            next_rdata[`PWD_CTL_RESET_ENABLE] = reset_enable;
         end
         `PWD_ADDR_CLOCK_TIMEOUT: begin
            // Select bits 7 and 6, then divisors, then select bit 2
            next_rdata[`PWD_CK_SEL_BIT1] = timeout_select[1];
            next_rdata[`PWD_CK_SEL_BIT0] = timeout_select[0];
            next_rdata[`PWD_CK_DIV_HI:`PWD_CK_DIV_LO] = timer_divisor_select;
            next_rdata[`PWD_CK_SEL_BIT2] = timeout_select[2];
            // Low bits are not ours but read as their reset value
            next_rdata[1:0] = `PWD_CK_RSVD_VALUE;
         end
         `PWD_ADDR_INT_STATUS: begin
            // Only two events are defined
            next_rdata[1:0] = int_status;
         end
         `PWD_ADDR_INT_MASK: begin
            // Mask reads back as written
            next_rdata[1:0] = int_mask;
         end
         default: begin
            // Unmapped addresses
            next_rdata = 8'h00;
         end
      endcase
   end

   // Read data stand only in the cycle after the strobe
   // Zero between reads lets the core OR several read paths together
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata <= 8'h00;
      end else if (ce) begin
         if (rd) begin
            rdata <= next_rdata;
         end else begin
            rdata <= 8'h00;
         end
      end
   end

endmodule

`default_nettype wire

// *** include/pwd_defs.vh ***
`ifndef PWD_DEFS_VH
`define PWD_DEFS_VH

// Register offsets on the special function register port
`define PWD_ADDR_CLOCK_TIMEOUT 8'h8E
`define PWD_ADDR_CONTROL 8'hD8
`define PWD_ADDR_INT_STATUS 8'hF0
`define PWD_ADDR_INT_MASK 8'hF1

// Reset values
`define PWD_RST_CLOCK_TIMEOUT 8'hC7
`define PWD_RST_CONTROL 8'h02
`define PWD_RST_INT_STATUS 2'h0
`define PWD_RST_INT_MASK 2'h0
`define PWD_RST_TIMEOUT_SEL 3'h7
`define PWD_RST_DIVISORS 3'h0

// Watchdog control and status field positions
`define PWD_CTL_EXPIRY_FLAG 3
`define PWD_CTL_RESET_FLAG 2
`define PWD_CTL_RESET_ENABLE 1
`define PWD_CTL_RESTART 0

// Clock and timeout control field positions
`define PWD_CK_SEL_BIT1 7
`define PWD_CK_SEL_BIT0 6
`define PWD_CK_DIV_HI 5
`define PWD_CK_DIV_LO 3
`define PWD_CK_SEL_BIT2 2
`define PWD_CK_RSVD_VALUE 2'h3

// Interrupt status and mask field positions
`define PWD_INT_EXPIRY 0
`define PWD_INT_REFUSED 1

// Expiry counts per timeout select code
`define PWD_LIMIT_0 131072
`define PWD_LIMIT_1 1048576
`define PWD_LIMIT_2 8388608
`define PWD_LIMIT_3 67108864
`define PWD_LIMIT_4 134217728
`define PWD_LIMIT_5 268435456
`define PWD_LIMIT_6 536870912
`define PWD_LIMIT_7 1073741824

// Cycles after reset release before the reset cause is caught
`define PWD_CAUSE_SETTLE 2'h3

`endif

// *** design/pwd_counter.v ***
`timescale 1ns/1ps
`default_nettype none

// Free running watchdog counter with a programmable terminal value
module pwd_counter #(
   parameter COUNT_W = 30
) (
   input wire clk,
   input wire rst_n,
   input wire ce,
   input wire run,
   input wire clear,
   input wire [COUNT_W-1:0] terminal,
   output reg expire
);

   // Current count
   reg [COUNT_W-1:0] count;

   // Count, restart on clear, wrap and pulse at the terminal value
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         count <= {COUNT_W{1'b0}};
         expire <= 1'b0;
      end else if (ce) begin
         expire <= 1'b0;
         if (clear) begin
            // Restart wins over counting in the same cycle
            count <= {COUNT_W{1'b0}};
         end else if (run) begin
            if (count >= terminal) begin
               // Compare with >= so a shortened select takes effect at once
               count <= {COUNT_W{1'b0}};
               expire <= 1'b1;
            end else begin
               count <= count + {{(COUNT_W-1){1'b0}}, 1'b1};
            end
         end
      end
   end

endmodule

`default_nettype wire

// *** testbench/pwd_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
// Port-level watch on the watchdog control block
module pwd_sva (
   input wire clk,
   input wire rst_n,
   input wire ce,
   input wire [7:0] addr,
   input wire [7:0] wdata,
   input wire wr,
   input wire rd,
   input wire [7:0] rdata,
   input wire timed_access_guard,
   input wire watchdog_interrupt_enable,
   input wire wdt_irq_req,
   input wire sys_reset_req,
   input wire [2:0] timer_divisor_select
);
   default clocking @(posedge clk); endclocking
   // A frozen clock enable holds every output, so it pauses the watch
   default disable iff (!rst_n || !ce);
   // Clock register write, a quiet cycle, then its read
   sequence s_ck_rw;
      wr && addr == 8'h8E ##1 !wr ##1 rd && addr == 8'h8E;
   endsequence
   // Control write with the guard shut, then its read
   sequence s_ctl_rw;
      wr && addr == 8'hD8 && !timed_access_guard ##1 !wr ##1 rd && addr == 8'hD8;
   endsequence
   chk_idle_read: assert property (!rd |=> rdata == 8'h00)
      else $error("read data not idle");
   chk_irq_enable: assert property (wdt_irq_req |-> $past(watchdog_interrupt_enable))
      else $error("interrupt request without enable");
   chk_reset_sticky: assert property (sys_reset_req |=> sys_reset_req)
      else $error("system reset request dropped");
   chk_restart_blank: assert property (rd && addr == 8'hD8 |=> rdata[0] == 1'b0)
      else $error("restart bit reads set");
   chk_ck_low_bits: assert property (rd && addr == 8'h8E |=> rdata[1:0] == 2'h3)
      else $error("clock register low bits wrong");
   chk_divisor_follow: assert property (wr && addr == 8'h8E |=> timer_divisor_select == $past(wdata[5:3]))
      else $error("divisor output not updated");
   chk_sel_readback: assert property (s_ck_rw |=> rdata[7:2] == $past(wdata[7:2], 3))
      else $error("timeout select readback wrong");
   chk_enable_unlocked: assert property (s_ctl_rw |=> rdata[1] == $past(wdata[1], 3))
      else $error("reset enable write blocked");
endmodule
bind pwd_top pwd_sva i_sva (.clk(clk), .rst_n(rst_n), .ce(ce), .addr(addr), .wdata(wdata),
   .wr(wr), .rd(rd), .rdata(rdata), .timed_access_guard(timed_access_guard),
   .watchdog_interrupt_enable(watchdog_interrupt_enable), .wdt_irq_req(wdt_irq_req),
   .sys_reset_req(sys_reset_req), .timer_divisor_select(timer_divisor_select));
`default_nettype wire

// *** testbench/pwd_cpu.sv ***
`timescale 1ns/1ps
`default_nettype none
// Core side of the register port
module pwd_cpu (
   input wire logic clk,
   input wire logic [7:0] rdata,
   output logic [7:0] addr,
   output logic [7:0] wdata,
   output logic wr,
   output logic rd,
   output logic guard
);
   initial begin
      addr = 8'h00;
      wdata = 8'h00;
      wr = 1'b0;
      rd = 1'b0;
      guard = 1'b0;
   end
   // One write cycle; data scrambled after so no stale value lingers
   task automatic wreg(input logic [7:0] a, input logic [7:0] d, input logic open);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      guard <= open;
      @(posedge clk);
      wr <= 1'b0;
      guard <= 1'b0;
      wdata <= ~d;
   endtask
   // Read strobe, then take data in the following cycle
   task automatic rreg(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(posedge clk);
      d = rdata;
   endtask
endmodule
`default_nettype wire

// *** testbench/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic ie = 1'b0;
   logic halted = 1'b1;
   logic cause = 1'b0;
   logic ce = 1'b1;
   wire [7:0] addr, wdata, rdata;
   wire wr, rd, guard, irq_req, sys_rst, irq;
   wire [2:0] div;
   int err_total = 0;
   int n_tests = 0;
   int n;
   logic [7:0] d;
   // 200 MHz
   always #2.5 clk = ~clk;
   // Short expiry counts keep the run brief; each code doubles the last
   localparam int LIM0 = 4, LIM1 = 8, LIM2 = 16, LIM3 = 32, LIM4 = 64, LIM5 = 128, LIM6 = 256, LIM7 = 512;
   pwd_top #(.LIMIT_0(LIM0), .LIMIT_1(LIM1), .LIMIT_2(LIM2), .LIMIT_3(LIM3),
      .LIMIT_4(LIM4), .LIMIT_5(LIM5), .LIMIT_6(LIM6), .LIMIT_7(LIM7)) i_dut (
      .clk(clk), .rst_n(rst_n), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .timed_access_guard(guard), .watchdog_interrupt_enable(ie),
      .cpu_halted(halted), .wdt_reset_cause(cause), .wdt_irq_req(irq_req),
      .sys_reset_req(sys_rst), .irq(irq), .timer_divisor_select(div));
   pwd_cpu i_cpu (.clk(clk), .rdata(rdata), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .guard(guard));
   task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic rchk(input logic [7:0] a, input logic [7:0] e, input string nm);
      i_cpu.rreg(a, d);
      chk(nm, d, e);
   endtask
   task automatic cyc(input int k);
      repeat (k) @(posedge clk);
   endtask
   task automatic hold(input logic h);
      @(posedge clk);
      halted <= h;
   endtask
   // Reset with a chosen cause; cause needs a few edges to be caught
   task automatic do_reset(input logic c);
      @(posedge clk);
      rst_n <= 1'b0;
      cause <= c;
      cyc(10);
      rst_n <= 1'b1;
      cyc(6);
   endtask
   task automatic summarize;
      $display("Comparisons %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic t_defaults;
      rchk(8'hD8, 8'h02, "control");
      rchk(8'h8E, 8'hC7, "clock");
      rchk(8'h3C, 8'h00, "unmapped");
      chk("sys idle", {7'h00, sys_rst}, 8'h00);
   endtask
   // Every select code, period measured from a restart
   task automatic t_select;
      logic [7:0] v;
      ie <= 1'b1;
      for (int c = 0; c < 8; c++) begin
         v = {c[1:0], c[2:0], c[2], 2'b00};
         hold(1'b1);
         i_cpu.wreg(8'hD8, 8'h00, 1'b0);
         i_cpu.wreg(8'h8E, v, 1'b0);
         rchk(8'h8E, v | 8'h03, "select");
         chk("divisor", {5'h00, div}, {5'h00, c[2:0]});
         i_cpu.wreg(8'hD8, 8'h01, 1'b1);
         hold(1'b0);
         n = 0;
         while (irq_req !== 1'b1 && n < 600) begin
            @(posedge clk);
            n++;
         end
         chk("period", {7'h00, n >= (LIM0 << c) && n <= (LIM0 << c) + 4}, 8'h01);
         chk("no reset", {7'h00, sys_rst}, 8'h00);
      end
   endtask
   task automatic t_flag;
      hold(1'b1);
      ie <= 1'b0;
      i_cpu.wreg(8'h8E, 8'h00, 1'b0);
      cyc(2);
      chk("irq req", {7'h00, irq_req}, 8'h00);
      rchk(8'hD8, 8'h08, "flag");
      i_cpu.wreg(8'hD8, 8'h00, 1'b0);
      rchk(8'hD8, 8'h00, "flag clear");
      cyc(20);
      rchk(8'hD8, 8'h00, "halted");
      hold(1'b0);
      cyc(10);
      rchk(8'hD8, 8'h08, "flag again");
      i_cpu.wreg(8'hF1, 8'h01, 1'b0);
      cyc(2);
      chk("irq on", {7'h00, irq}, 8'h01);
      i_cpu.wreg(8'hF1, 8'h00, 1'b0);
      cyc(2);
      chk("irq masked", {7'h00, irq}, 8'h00);
      hold(1'b1);
      i_cpu.wreg(8'hF0, 8'h03, 1'b0);
      i_cpu.wreg(8'hF1, 8'h01, 1'b0);
      cyc(2);
      chk("irq cleared", {7'h00, irq}, 8'h00);
   endtask
   // Clock enable low freezes counter and registers
   task automatic t_freeze;
      i_cpu.wreg(8'hD8, 8'h01, 1'b1);
      @(posedge clk);
      ce <= 1'b0;
      hold(1'b0);
      cyc(20);
      i_cpu.wreg(8'h8E, 8'h38, 1'b0);
      chk("frozen divisor", {5'h00, div}, 8'h00);
      @(posedge clk);
      ce <= 1'b1;
      rchk(8'hD8, 8'h00, "frozen count");
      hold(1'b1);
      i_cpu.wreg(8'hF0, 8'h03, 1'b0);
      rchk(8'h8E, 8'h03, "frozen write");
   endtask
   // Restarts faster than the period, open then locked
   task automatic t_restart;
      i_cpu.wreg(8'hD8, 8'h01, 1'b1);
      hold(1'b0);
      repeat (8) i_cpu.wreg(8'hD8, 8'h01, 1'b1);
      rchk(8'hF0, 8'h00, "open restart");
      repeat (8) i_cpu.wreg(8'hD8, 8'h01, 1'b0);
      rchk(8'hF0, 8'h03, "locked restart");
      hold(1'b1);
      cyc(3);
      i_cpu.wreg(8'hD8, 8'h02, 1'b0);
      rchk(8'hD8, 8'h02, "enable unlocked");
   endtask
   task automatic t_sysreset;
      hold(1'b0);
      n = 0;
      while (sys_rst !== 1'b1 && n < 40) begin
         @(posedge clk);
         n++;
      end
      chk("sys reset", {7'h00, sys_rst}, 8'h01);
      do_reset(1'b1);
      rchk(8'hD8, 8'h06, "cause wdt");
      do_reset(1'b0);
      rchk(8'hD8, 8'h02, "cause other");
   endtask
   initial begin
      do_reset(1'b0);
      t_defaults;
      t_select;
      t_flag;
      t_freeze;
      t_restart;
      t_sysreset;
      summarize;
   end
   // Hang guard, well past the expected run
   initial begin
      cyc(20000);
      err_total++;
      summarize;
   end
endmodule
`default_nettype wire
